// ### verilog/bpm_pkg.sv
// Shared constants for the block transfer engine mask and order logic
package bpm_pkg;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned MEM_AW    = 32;
  localparam int unsigned COORD_W   = 16;
  localparam int unsigned CH_W      = 8;
  localparam int unsigned NUM_CH    = 4;
  localparam int unsigned ROP_W     = 8;
  //////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_SRC_XY  = 8'h08;
  localparam logic [7:0] OFF_DST_XY  = 8'h0C;
  localparam logic [7:0] OFF_SIZE    = 8'h10;
  localparam logic [7:0] OFF_BASE    = 8'h14;
  localparam logic [7:0] OFF_PITCH   = 8'h18;
  localparam logic [7:0] OFF_ROP     = 8'h1C;
  localparam logic [7:0] OFF_FG      = 8'h20;
  localparam logic [7:0] OFF_BG      = 8'h24;
  localparam logic [7:0] OFF_PAT_COL = 8'h28;
  localparam logic [7:0] OFF_MSRC_LO = 8'h2C;
  localparam logic [7:0] OFF_MSRC_HI = 8'h30;
  localparam logic [7:0] OFF_MPAT_LO = 8'h34;
  localparam logic [7:0] OFF_MPAT_HI = 8'h38;
  localparam logic [7:0] OFF_WRITTEN = 8'h3C;
  //////////////////////////////////////////////////////////////////////////
  // Control and status register fields
  localparam int unsigned CTRL_START     = 0;
  localparam int unsigned CTRL_CORNER_LO = 1;
  localparam int unsigned CTRL_CORNER_HI = 2;
  localparam int unsigned CTRL_AUTO      = 3;
  localparam int unsigned CTRL_MSEL_LO   = 4;
  localparam int unsigned CTRL_MSEL_HI   = 5;
  localparam int unsigned CTRL_TMODE_LO  = 6;
  localparam int unsigned CTRL_TMODE_HI  = 8;
  localparam int unsigned STAT_BUSY      = 0;
  localparam int unsigned STAT_DONE      = 1;
  localparam int unsigned STAT_XLEFT     = 2;
  localparam int unsigned STAT_YUP       = 3;
  //////////////////////////////////////////////////////////////////////////
  // Mask select, transparency modes and reset values
  localparam int unsigned MSEL_SRC = 0;
  localparam int unsigned MSEL_PAT = 1;
  localparam logic [2:0] TM_NONE       = 3'h0;
  localparam logic [2:0] TM_DST_IN     = 3'h1;
  localparam logic [2:0] TM_DST_OUT    = 3'h2;
  localparam logic [2:0] TM_SRC_IN     = 3'h3;
  localparam logic [2:0] TM_SRC_OUT    = 3'h4;
  localparam logic [7:0] ROP_RESET     = 8'hCC;
  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
endpackage : bpm_pkg

// ### verilog/bpm_range_cmp.sv
// Per-channel colour range comparison of one pixel
`timescale 1ns/100ps
module bpm_range_cmp
  import bpm_pkg::*;
#(
  parameter int unsigned CHANNELS = bpm_pkg::NUM_CH,
  parameter int unsigned WIDTH    = bpm_pkg::CH_W
) (
  input  wire logic [CHANNELS*WIDTH-1:0] pixel,
  input  wire logic [CHANNELS*WIDTH-1:0] low_limit,
  input  wire logic [CHANNELS*WIDTH-1:0] high_limit,
  output logic                           in_range
);
  logic [CHANNELS-1:0] ch_ok;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
      // Background is the lower bound, foreground the upper
      assign ch_ok[g] =
        (pixel[g*WIDTH +: WIDTH] >= low_limit[g*WIDTH +: WIDTH]) &&
        (pixel[g*WIDTH +: WIDTH] <= high_limit[g*WIDTH +: WIDTH]); // R6
    end
  endgenerate

  assign in_range = &ch_ok;
endmodule : bpm_range_cmp

// ### verilog/bpm_rop.sv
// Bitwise raster operation of source, pattern and destination
`timescale 1ns/100ps
module bpm_rop
  import bpm_pkg::*;
#(
  parameter int unsigned WIDTH = bpm_pkg::DATA_W
) (
  input  wire logic [7:0]       code,
  input  wire logic [WIDTH-1:0] src,
  input  wire logic [WIDTH-1:0] pat,
  input  wire logic [WIDTH-1:0] dst,
  output logic      [WIDTH-1:0] result
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      // Code bit index is {P,S,D}; hence FF gives all ones
      assign result[g] = code[{pat[g], src[g], dst[g]}]; // R13
    end
  endgenerate
endmodule : bpm_rop

// ### verilog/bpm_blit.sv
// Block transfer engine: pixel write masking and overlap-safe ordering
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/100ps
// Operation
// R1: Mono source or mono pattern bits, picked by mask select, mask writes.
// R2: Colour pattern never masks; it only feeds the raster operation.
// R3: A zero mask bit skips the whole destination pixel write.
// R4: With both mono operands selected the write enable is their AND.
// R5: A 3-bit transparency mode picks colour-compare masking or none.
// R6: Colour compare checks each channel of dest or source in [bg, fg].
// R7: Rectangle copy detects overlap and picks a safe traversal direction.
// R8: By default traversal starts at the top-left pixel of both rectangles.
// R9: Any of the four corners may be chosen as the start.
// R10: Each source pixel is fetched before its destination is written.
// R11: Software should pick a start corner inside the overlap area.
// R12: With no mask and no transparency every pixel is written.
// R13: Source, pattern and destination combine bitwise; code FF gives ones.
module bpm_blit (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [bpm_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [bpm_pkg::DATA_W-1:0]  pwdata,
  output logic      [bpm_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic                             mem_req,
  output logic                             mem_we,
  output logic      [bpm_pkg::MEM_AW-1:0]  mem_addr,
  output logic      [bpm_pkg::DATA_W-1:0]  mem_wdata,
  output logic      [3:0]                  mem_be,
  input  wire logic [bpm_pkg::DATA_W-1:0]  mem_rdata,
  input  wire logic                        mem_ack,
  output logic                             busy
);
  import bpm_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_RD_SRC, ST_RD_DST, ST_DECIDE, ST_WR, ST_STEP
  } bpm_state_type;

  bpm_state_type       state;
  logic [8:0]          ctrl;
  logic [31:0]         src_xy;
  logic [31:0]         dst_xy;
  logic [31:0]         size;
  logic [31:0]         base;
  logic [31:0]         pitch;
  logic [7:0]          rop;
  logic [31:0]         fg;
  logic [31:0]         bg;
  logic [31:0]         pat_col;
  logic [63:0]         mono_src;
  logic [63:0]         mono_pat;
  logic [31:0]         written;
  logic                done;
  logic                x_left;
  logic                y_up;
  logic [COORD_W-1:0]  col_cnt;
  logic [COORD_W-1:0]  row_cnt;
  logic [31:0]         src_px;
  logic [31:0]         dst_px;
  logic                pix_we;

  //////////////////////////////////////////////////////////////////////////
  // APB decode
  logic                apb_access;
  logic                apb_wr;
  logic                addr_ok;
  logic [31:0]         rd_mux;

  assign apb_access = psel & penable;
  assign apb_wr     = apb_access & pready & pwrite;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = RST_ZERO;
    case (paddr)
      OFF_CTRL:    rd_mux = {23'h0, ctrl[8:1], 1'b0};
      OFF_STATUS:  rd_mux = {28'h0, y_up, x_left, done, busy};
      OFF_SRC_XY:  rd_mux = src_xy;
      OFF_DST_XY:  rd_mux = dst_xy;
      OFF_SIZE:    rd_mux = size;
      OFF_BASE:    rd_mux = base;
      OFF_PITCH:   rd_mux = pitch;
      OFF_ROP:     rd_mux = {24'h0, rop};
      OFF_FG:      rd_mux = fg;
      OFF_BG:      rd_mux = bg;
      OFF_PAT_COL: rd_mux = pat_col;
      OFF_MSRC_LO: rd_mux = mono_src[31:0];
      OFF_MSRC_HI: rd_mux = mono_src[63:32];
      OFF_MPAT_LO: rd_mux = mono_pat[31:0];
      OFF_MPAT_HI: rd_mux = mono_pat[63:32];
      OFF_WRITTEN: rd_mux = written;
      default:     addr_ok = 1'b0;
    endcase
  end

  // One wait state keeps every answer on a flip-flop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= RST_ZERO;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_access & ~pready;
      prdata  <= (apb_access & ~pready & ~pwrite) ? rd_mux : RST_ZERO;
      pslverr <= apb_access & ~pready & ~addr_ok;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers; held stable while the engine runs
  logic cfg_wr;
  assign cfg_wr = apb_wr & ~busy;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl     <= 9'h000;
      src_xy   <= RST_ZERO;
      dst_xy   <= RST_ZERO;
      size     <= RST_ZERO;
      base     <= RST_ZERO;
      pitch    <= RST_ZERO;
      rop      <= ROP_RESET;
      fg       <= RST_ZERO;
      bg       <= RST_ZERO;
      pat_col  <= RST_ZERO;
      mono_src <= 64'h0;
      mono_pat <= 64'h0;
    end else begin
      ctrl[CTRL_START] <= cfg_wr && paddr == OFF_CTRL && pwdata[CTRL_START];
      if (cfg_wr) begin
        case (paddr)
          OFF_CTRL:    ctrl[8:1]       <= pwdata[8:1];
          OFF_SRC_XY:  src_xy          <= pwdata;
          OFF_DST_XY:  dst_xy          <= pwdata;
          OFF_SIZE:    size            <= pwdata;
          OFF_BASE:    base            <= pwdata;
          OFF_PITCH:   pitch           <= pwdata;
          OFF_ROP:     rop             <= pwdata[7:0];
          OFF_FG:      fg              <= pwdata;
          OFF_BG:      bg              <= pwdata;
          OFF_PAT_COL: pat_col         <= pwdata;
          OFF_MSRC_LO: mono_src[31:0]  <= pwdata;
          OFF_MSRC_HI: mono_src[63:32] <= pwdata;
          OFF_MPAT_LO: mono_pat[31:0]  <= pwdata;
          OFF_MPAT_HI: mono_pat[63:32] <= pwdata;
          default:     ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Geometry and overlap detection
  logic [COORD_W-1:0] sx, sy, dx, dy, w, h;
  logic [COORD_W-1:0] abs_dx, abs_dy;
  logic               overlap;
  logic               next_x_left;
  logic               next_y_up;

  assign sx = src_xy[15:0];
  assign sy = src_xy[31:16];
  assign dx = dst_xy[15:0];
  assign dy = dst_xy[31:16];
  assign w  = size[15:0];
  assign h  = size[31:16];
  assign abs_dx = (dx > sx) ? dx - sx : sx - dx;
  assign abs_dy = (dy > sy) ? dy - sy : sy - dy;
  assign overlap = (abs_dx < w) && (abs_dy < h); // R7

  always_comb begin
    // Corner field: bit 0 right-to-left, bit 1 bottom-to-top
    next_x_left = ctrl[CTRL_CORNER_LO]; // R8 R9
    next_y_up   = ctrl[CTRL_CORNER_HI]; // R9
    if (ctrl[CTRL_AUTO]) begin
      // Start on the corner of the source that lies in the overlap
      next_x_left = overlap && (dx > sx); // R7 R10
      next_y_up   = overlap && (dy > sy); // R7 R10
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Current pixel position and addresses
  logic [COORD_W-1:0] col;
  logic [COORD_W-1:0] row;
  logic [COORD_W-1:0] src_x, src_y, dst_x, dst_y;
  logic [31:0]        src_addr;
  logic [31:0]        dst_addr;
  logic               last_col;
  logic               last_row;

  assign col   = x_left ? w - 16'h0001 - col_cnt : col_cnt;
  assign row   = y_up   ? h - 16'h0001 - row_cnt : row_cnt;
  assign src_x = sx + col;
  assign src_y = sy + row;
  assign dst_x = dx + col;
  assign dst_y = dy + row;
  assign src_addr = base + 32'({16'h0, src_y} * pitch)
                  + {14'h0, src_x, 2'b00};
  assign dst_addr = base + 32'({16'h0, dst_y} * pitch)
                  + {14'h0, dst_x, 2'b00};
  assign last_col = (col_cnt == w - 16'h0001);
  assign last_row = (row_cnt == h - 16'h0001);

  //////////////////////////////////////////////////////////////////////////
  // Write mask: mono operands and colour compare
  logic [5:0]  bit_idx;
  logic        mono_we;
  logic        colour_we;
  logic        dst_in;
  logic        src_in;
  logic [1:0]  msel;
  logic [2:0]  tmode;
  logic [31:0] rop_out;

  assign msel    = ctrl[CTRL_MSEL_HI:CTRL_MSEL_LO];
  assign tmode   = ctrl[CTRL_TMODE_HI:CTRL_TMODE_LO];
  // The mono bits tile the rectangle as an 8x8 block
  assign bit_idx = {row[2:0], col[2:0]};
  // Colour pattern has no path into the mask
  assign mono_we = (msel[MSEL_SRC] ? mono_src[bit_idx] : 1'b1) // R1 R3
                 & (msel[MSEL_PAT] ? mono_pat[bit_idx] : 1'b1); // R1 R2 R4

  always_comb begin
    case (tmode) // R5
      TM_DST_IN:  colour_we = dst_in; // R6
      TM_DST_OUT: colour_we = ~dst_in; // R6
      TM_SRC_IN:  colour_we = src_in; // R6
      TM_SRC_OUT: colour_we = ~src_in; // R6
      default:    colour_we = 1'b1; // R12
    endcase
  end

  bpm_range_cmp u_cmp_dst (
    .pixel      (dst_px),
    .low_limit  (bg),
    .high_limit (fg),
    .in_range   (dst_in)
  );

  bpm_range_cmp u_cmp_src (
    .pixel      (src_px),
    .low_limit  (bg),
    .high_limit (fg),
    .in_range   (src_in)
  );

  bpm_rop u_rop (
    .code   (rop),
    .src    (src_px),
    .pat    (pat_col),
    .dst    (dst_px),
    .result (rop_out)
  );

  //////////////////////////////////////////////////////////////////////////
  // Traversal state machine
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state   <= ST_IDLE;
      col_cnt <= 16'h0000;
      row_cnt <= 16'h0000;
      x_left  <= 1'b0;
      y_up    <= 1'b0;
      src_px  <= RST_ZERO;
      dst_px  <= RST_ZERO;
      pix_we  <= 1'b0;
      busy    <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (ctrl[CTRL_START]) begin
            state <= ST_SETUP;
            busy  <= 1'b1;
          end
        end
        ST_SETUP: begin
          x_left  <= next_x_left;
          y_up    <= next_y_up;
          col_cnt <= 16'h0000;
          row_cnt <= 16'h0000;
          if (w == 16'h0000 || h == 16'h0000) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
          end else begin
            state <= ST_RD_SRC;
          end
        end
        ST_RD_SRC: begin
          if (mem_req && mem_ack) begin
            src_px <= mem_rdata; // R10
            state  <= ST_RD_DST;
          end
        end
        ST_RD_DST: begin
          if (mem_req && mem_ack) begin
            dst_px <= mem_rdata;
            state  <= ST_DECIDE;
          end
        end
        ST_DECIDE: begin
          pix_we <= mono_we & colour_we; // R3 R12
          state  <= (mono_we & colour_we) ? ST_WR : ST_STEP; // R3
        end
        ST_WR: begin
          if (mem_req && mem_ack) begin
            state <= ST_STEP;
          end
        end
        ST_STEP: begin
          state <= ST_RD_SRC;
          if (last_col) begin
            col_cnt <= 16'h0000;
            row_cnt <= row_cnt + 16'h0001;
            if (last_row) begin
              state <= ST_IDLE;
              busy  <= 1'b0;
            end
          end else begin
            col_cnt <= col_cnt + 16'h0001;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Memory port; request held until acknowledged
  logic mem_done;
  assign mem_done = mem_req & mem_ack;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= RST_ZERO;
      mem_wdata <= RST_ZERO;
      mem_be    <= 4'h0;
    end else if (mem_done) begin
      mem_req <= 1'b0;
      mem_we  <= 1'b0;
      mem_be  <= 4'h0;
    end else if (!mem_req) begin
      case (state)
        ST_RD_SRC: begin
          mem_req  <= 1'b1;
          mem_addr <= src_addr;
        end
        ST_RD_DST: begin
          mem_req  <= 1'b1;
          mem_addr <= dst_addr;
        end
        ST_WR: begin
          // Whole pixel written or none at all
          mem_req   <= 1'b1;
          mem_we    <= 1'b1;
          mem_be    <= 4'hF; // R3
          mem_addr  <= dst_addr;
          mem_wdata <= rop_out; // R13
        end
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status: done flag and written-pixel count
  logic set_done;
  logic clr_done;
  assign set_done = (state == ST_STEP) && last_col && last_row;
  assign clr_done = apb_wr && paddr == OFF_STATUS && pwdata[STAT_DONE];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else if (set_done) begin
      done <= 1'b1;
    end else if (clr_done) begin
      done <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      written <= RST_ZERO;
    end else if (state == ST_SETUP) begin
      written <= RST_ZERO;
    end else if (state == ST_WR && mem_done && pix_we) begin
      written <= written + 32'h0000_0001;
    end
  end
endmodule : bpm_blit

// ### dv/bpm_blit_assertions.sv
// Port level checks of the blit engine
`timescale 1ns/100ps
module bpm_blit_assertions
  import bpm_pkg::*;
(
  input wire logic                       core_clk,
  input wire logic                       rst_n,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [bpm_pkg::ADDR_W-1:0] paddr,
  input wire logic [bpm_pkg::DATA_W-1:0] pwdata,
  input wire logic [bpm_pkg::DATA_W-1:0] prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       mem_req,
  input wire logic                       mem_we,
  input wire logic [bpm_pkg::MEM_AW-1:0] mem_addr,
  input wire logic [3:0]                 mem_be,
  input wire logic                       mem_ack,
  input wire logic                       busy
);
  // Reads since the last write, saturating
  logic [1:0] rd_run;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_run <= 2'h0;
    end else if (mem_req && mem_ack) begin
      rd_run <= mem_we ? 2'h0 : rd_run + {1'b0, rd_run != 2'h3};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_rdz; !pready |-> prdata == RST_ZERO; endproperty
  a_rdz: assert property (p_rdz) else $error("prdata not zero");
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_hold: assert property (p_hold) else $error("request not held");
  property p_drop; mem_req && mem_ack |=> !mem_req; endproperty
  a_drop: assert property (p_drop) else $error("request after ack");
  property p_bew; mem_req && mem_we |-> mem_be == 4'hF; endproperty
  a_bew: assert property (p_bew) else $error("partial pixel write");
  property p_ber; mem_req && !mem_we |-> mem_be == 4'h0; endproperty
  a_ber: assert property (p_ber) else $error("enables on read");
  property p_rdfirst; mem_req && mem_we |-> rd_run >= 2'h2; endproperty
  a_rdfirst: assert property (p_rdfirst) else $error("write before read");
  property p_busy; mem_req |-> busy; endproperty
  a_busy: assert property (p_busy) else $error("access while idle");
  property p_start;
    psel && penable && pready && pwrite && paddr == OFF_CTRL
      && pwdata[CTRL_START] && !busy |=> ##1 busy;
  endproperty
  a_start: assert property (p_start) else $error("start ignored");
endmodule : bpm_blit_assertions

bind bpm_blit bpm_blit_assertions i_bpm_blit_assertions (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be),
  .mem_ack(mem_ack), .busy(busy)
);

// ### dv/bpm_mem_model.sv
// Behavioural pixel memory answering the engine's requests
`timescale 1ns/100ps
module bpm_mem_model
  import bpm_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       mem_req,
  input  wire logic                       mem_we,
  input  wire logic [bpm_pkg::MEM_AW-1:0] mem_addr,
  input  wire logic [bpm_pkg::DATA_W-1:0] mem_wdata,
  input  wire logic [3:0]                 mem_be,
  input  wire logic [3:0]                 wait_cycles,
  output logic      [bpm_pkg::DATA_W-1:0] mem_rdata,
  output logic                            mem_ack
);
  logic [DATA_W-1:0] mem [256];
  logic [3:0]        cnt;
  logic [7:0]        idx;
  assign idx = mem_addr[9:2];
  // Plain always: the bench preloads the array before reset ends
  always @(posedge core_clk) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 32'h5A5A_5A5A;
    end else if (!mem_ack && mem_req && cnt == wait_cycles) begin
      mem_ack <= 1'b1;
      cnt <= 4'h0;
      if (mem_we) begin
        for (int b = 0; b < 4; b++) begin
          if (mem_be[b]) mem[idx][8*b +: 8] <= mem_wdata[8*b +: 8];
        end
      end else begin
        mem_rdata <= mem[idx];
      end
    end else begin
      // Data toggles off the ack so stale reads cannot pass
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : bpm_mem_model

// ### dv/test_bpm_blit.sv
// Register level tests of the blit engine on a pixel memory model
`timescale 1ns/100ps
module test_bpm_blit;
  import bpm_pkg::*;
  localparam logic [63:0] MSRC_V = 64'h3C5A_0FF0_A5C3_96E1;
  localparam logic [63:0] MPAT_V = 64'hF00F_33CC_6699_C3A5;
  localparam logic [31:0] PAT_V  = 32'h5AC3_0F0F;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rq, fw_addr;
  logic        mem_req, mem_we, mem_ack, busy, re, fw_seen;
  logic [3:0]  mem_be, mem_wait;
  int          error_cnt, num_checks;

  bpm_blit i_bpm_blit (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .busy(busy));
  bpm_mem_model i_bpm_mem_model (.core_clk(core_clk), .rst_n(rst_n),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_be(mem_be), .wait_cycles(mem_wait),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (mem_req && mem_ack && mem_we && !fw_seen) begin
      fw_addr <= mem_addr;
      fw_seen <= 1'b1;
    end
  end
  ////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      final_report();
    end
    @(posedge core_clk);
  endtask : apb

  function automatic logic inr(input logic [31:0] p);
    inr = 1'b1;
    for (int b = 0; b < 4; b++) begin
      if (p[8*b +: 8] < 8'h08 || p[8*b +: 8] > 8'h20) inr = 1'b0;
    end
  endfunction : inr

  task automatic blit(input int sx, sy, dx, dy, w, h,
                      input logic [8:0] ctl, input logic [7:0] rop);
    logic [31:0] org [256];
    logic [31:0] ex [256];
    logic        en, ov, xl, yu;
    int          si, di, cnt, n;
    org = i_bpm_mem_model.mem;
    ex = org;
    cnt = 0;
    for (int r = 0; r < h; r++) begin
      for (int c = 0; c < w; c++) begin
        si = (sy + r) * 8 + sx + c;
        di = (dy + r) * 8 + dx + c;
        en = (!ctl[4] || MSRC_V[r*8+c]) && (!ctl[5] || MPAT_V[r*8+c]);
        case (ctl[8:6])
          TM_DST_IN:  en &= inr(org[di]);
          TM_DST_OUT: en &= !inr(org[di]);
          TM_SRC_IN:  en &= inr(org[si]);
          TM_SRC_OUT: en &= !inr(org[si]);
          default:    en &= 1'b1;
        endcase
        if (en) begin
          cnt++;
          ex[di] = rop == 8'hFF ? 32'hFFFF_FFFF : rop == 8'hF0 ? PAT_V : org[si];
        end
      end
    end
    ov = dx - sx < w && sx - dx < w && dy - sy < h && sy - dy < h;
    xl = ctl[3] ? ov && dx > sx : ctl[1];
    yu = ctl[3] ? ov && dy > sy : ctl[2];
    apb(1'b1, OFF_SRC_XY, {sy[15:0], sx[15:0]});
    apb(1'b1, OFF_DST_XY, {dy[15:0], dx[15:0]});
    apb(1'b1, OFF_SIZE, {h[15:0], w[15:0]});
    apb(1'b1, OFF_ROP, {24'h0, rop});
    fw_seen = 1'b0;
    apb(1'b1, OFF_CTRL, {23'h0, ctl | 9'h001});
    n = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
      n++;
    end while (rq[STAT_DONE] !== 1'b1 && n < 400);
    if (n >= 400) begin
      error_cnt++;
      final_report();
    end
    chk("direction", {30'h0, yu, xl}, {30'h0, rq[3:2]});
    chk("busy", 32'h0, {31'h0, busy});
    apb(1'b1, OFF_STATUS, 32'h2);
    apb(1'b0, OFF_WRITTEN, 32'h0);
    chk("written", cnt, rq);
    if (ctl[8:4] == 5'h0) begin
      n = (yu ? dy + h - 1 : dy) * 32 + (xl ? dx + w - 1 : dx) * 4;
      chk("first write", 32'(n), fw_addr);
    end
    for (int i = 0; i < 256; i++) begin
      chk("pixel", ex[i], i_bpm_mem_model.mem[i]);
    end
  endtask : blit
  ////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst_n = 1'b0;
    mem_wait = 4'h0;
    fw_seen = 1'b0;
    for (int i = 0; i < 256; i++) begin
      i_bpm_mem_model.mem[i] = {4{i[7:0]}};
    end
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, OFF_ROP, 32'h0);
    chk("rop reset", {24'h0, ROP_RESET}, rq);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, re});
    apb(1'b1, OFF_BASE, 32'h0);
    apb(1'b1, OFF_PITCH, 32'h20);
    apb(1'b1, OFF_FG, 32'h2020_2020);
    apb(1'b1, OFF_BG, 32'h0808_0808);
    apb(1'b1, OFF_PAT_COL, PAT_V);
    apb(1'b1, OFF_MSRC_LO, MSRC_V[31:0]);
    apb(1'b1, OFF_MSRC_HI, MSRC_V[63:32]);
    apb(1'b1, OFF_MPAT_LO, MPAT_V[31:0]);
    apb(1'b1, OFF_MPAT_HI, MPAT_V[63:32]);
    $display("test registers done");
    for (int k = 0; k < 4; k++) blit(0, 0, 4, 10, 3, 2, 9'(k << 1), 8'hCC);
    $display("test corners done");
    mem_wait <= 4'h2;
    for (int m = 1; m < 4; m++) blit(0, 0, 4, 1, 4, 4, 9'(m << 4), 8'hCC);
    $display("test masks done");
    for (int t = 1; t < 8; t++) blit(0, 0, 4, 1, 4, 4, 9'(t << 6), 8'hCC);
    $display("test transparency done");
    for (int q = 0; q < 4; q++) begin
      blit(2, 20, q[0] ? 3 : 1, q[1] ? 21 : 19, 4, 3, 9'h008, 8'hCC);
      // Software picks the corner inside the overlap itself
      blit(2, 20, q[0] ? 3 : 1, q[1] ? 21 : 19, 4, 3, 9'(q << 1), 8'hCC);
    end
    $display("test overlap done");
    blit(0, 0, 4, 28, 4, 2, 9'h000, 8'hFF);
    blit(0, 0, 4, 28, 4, 2, 9'h000, 8'hF0);
    $display("test raster done");
    final_report();
  end
endmodule : test_bpm_blit
